// ==== logic/ecp_pkg.sv ====
/*
 * Shared constants and carrier types for the enhanced host controller
 * capability parameter bank: offsets, field positions, reset values.
 * Assumes a single clock domain and a simple word-wide register port.
 */
`default_nettype none
package ecp_pkg;
	// ------------------------------------------------------------
	// Register offsets inside the capability space
	// ------------------------------------------------------------
	localparam logic [7:0] ECP_STRUCT_OFS = 8'h04;  // structural_params
	localparam logic [7:0] ECP_CAP_OFS    = 8'h08;  // capability_params

	// ------------------------------------------------------------
	// structural_params field positions
	// ------------------------------------------------------------
	localparam int ECP_PORTS_LSB  = 0;   // Port count, 4 bits
	localparam int ECP_PPC_BIT    = 4;   // Power switch flag
	localparam int ECP_PRR_BIT    = 7;   // Routing method flag
	localparam int ECP_PCC_LSB    = 8;   // Ports per companion, 4 bits
	localparam int ECP_CC_LSB     = 12;  // Companion count, 4 bits
	localparam int ECP_NIB        = 4;   // Nibble width
	localparam int ECP_ROUTE_N    = 15;  // Route array entries

	// ------------------------------------------------------------
	// capability_params field positions and reset values
	// ------------------------------------------------------------
	localparam int ECP_IST_LSB    = 4;   // Isochronous threshold, 4 bits
	localparam int ECP_FRAME_LIST_FLAG_BIT   = 1;   // Programmable frame list
	localparam int ECP_AC64_BIT   = 0;   // Addressing capability
	localparam logic [3:0] ECP_IST_RST  = 4'h1;
	localparam logic       ECP_FRAME_LIST_FLAG_RST = 1'h1;
	localparam logic       ECP_AC64_RST = 1'h0;

	// ------------------------------------------------------------
	// Structural defaults
	// ------------------------------------------------------------
	localparam logic [3:0] ECP_PORTS_DEF = 4'h2;
	localparam logic [3:0] ECP_PCC_DEF   = 4'h1;
	localparam logic [3:0] ECP_CC_DEF    = 4'h2;
	localparam logic       ECP_PPC_DEF   = 1'h1;
	localparam logic       ECP_PRR_DEF   = 1'h1;
	localparam logic [3:0] ECP_ONE       = 4'h1;  // Floor for counts
	localparam logic [31:0] ECP_ZERO     = 32'h0;

	// ------------------------------------------------------------
	// Carrier types
	// ------------------------------------------------------------
	typedef struct packed {
		logic        valid;  // One-cycle request strobe
		logic        write;  // 1 = write, 0 = read
		logic [7:0]  addr;   // Byte offset, word aligned
		logic [31:0] wdata;  // Write data (discarded)
	} ecp_req_t;

	typedef struct packed {
		logic        ack;    // One-cycle answer strobe
		logic [31:0] rdata;  // Read data, zero on write/unmapped
	} ecp_rsp_t;
endpackage : ecp_pkg
`default_nettype wire

// ==== logic/ecp_params.sv ====
/*
 * Capability parameter register bank: structural and capability words,
 * plus decoded flags and the companion route array for the port logic.
 * Assumes requests come from logic on clk; all values are fixed at build.
 */
`timescale 1ns/1ps
`default_nettype none
module ecp_params #(
	parameter logic [3:0]  PORTS      = ecp_pkg::ECP_PORTS_DEF,  // Physical ports
	parameter logic [3:0]  PER_COMP   = ecp_pkg::ECP_PCC_DEF,    // Ports per companion
	parameter logic [3:0]  COMPANIONS = ecp_pkg::ECP_CC_DEF,     // Companion count
	parameter logic        POWER_SW   = ecp_pkg::ECP_PPC_DEF,    // Power switches fitted
	parameter logic        ROUTE_EXPL = ecp_pkg::ECP_PRR_DEF,    // Explicit routing
	parameter logic [59:0] ROUTE_TBL  = 60'h000000000000010     // Explicit entries
) (
	// Clock and reset
	input  wire logic               clk,
	input  wire logic               reset,
	// Register port
	input  wire ecp_pkg::ecp_req_t  req,
	output var  ecp_pkg::ecp_rsp_t  rsp,
	// Decoded flags for the port and schedule logic
	output var  logic               routing_method_flag,
	output var  logic               port_power_switch_flag,
	output var  logic               frame_list_size_writable,
	output var  logic               addressing_capability_flag,
	output var  logic [3:0]         port_count,
	output var  logic [59:0]        companion_route_array
);
	import ecp_pkg::*;

	// ------------------------------------------------------------
	// Fixed word assembly
	// ------------------------------------------------------------
	// A zero port count has no meaning, so a bad build reports one
	function automatic logic [3:0] nonzero(input logic [3:0] v);
		nonzero = (v == 4'h0) ? ECP_ONE : v;
	endfunction

	localparam logic [3:0] PORTS_RPT = nonzero(PORTS);
	localparam logic [3:0] PCC_RPT   = nonzero(PER_COMP);

	function automatic logic [31:0] struct_word();
		logic [31:0] w;
		w = ECP_ZERO;
		w[ECP_PORTS_LSB +: ECP_NIB] = PORTS_RPT;
		w[ECP_PPC_BIT]              = POWER_SW;
		w[ECP_PRR_BIT]              = ROUTE_EXPL;
		w[ECP_PCC_LSB +: ECP_NIB]   = PCC_RPT;
		w[ECP_CC_LSB +: ECP_NIB]    = COMPANIONS;
		struct_word = w;
	endfunction

	// Reserved bits 31:8 and 3:2 stay zero
	function automatic logic [31:0] cap_word();
		logic [31:0] w;
		w = ECP_ZERO;
		w[ECP_IST_LSB +: ECP_NIB] = ECP_IST_RST;
		w[ECP_FRAME_LIST_FLAG_BIT]           = ECP_FRAME_LIST_FLAG_RST;
		w[ECP_AC64_BIT]           = ECP_AC64_RST;
		cap_word = w;
	endfunction

	// Route array: explicit table or consecutive grouping, valid entries only
	function automatic logic [59:0] route_word();
		logic [59:0] r;
		r = 60'h0;
		for (int i = 0; i < ECP_ROUTE_N; i++) begin
			if (i < int'(PORTS_RPT)) begin
				if (ROUTE_EXPL) begin
					r[i*ECP_NIB +: ECP_NIB] = ROUTE_TBL[i*ECP_NIB +: ECP_NIB];
				end else begin
					r[i*ECP_NIB +: ECP_NIB] = 4'(i / int'(PCC_RPT));
				end
			end
		end
		route_word = r;
	endfunction

	localparam logic [31:0] STRUCT_VAL = struct_word();
	localparam logic [31:0] CAP_VAL    = cap_word();
	localparam logic [59:0] ROUTE_VAL  = route_word();

	// ------------------------------------------------------------
	// Read path state
	// ------------------------------------------------------------
	ecp_rsp_t rsp_q;  // Registered answer
	ecp_rsp_t rsp_d;  // Next answer

	// Decode: whole-word answers only, writes and unmapped read zero
	always_comb begin
		rsp_d.ack   = req.valid;
		rsp_d.rdata = ECP_ZERO;
		if (!req.valid || req.write) begin
			rsp_d.rdata = ECP_ZERO;
		end else if (req.addr == ECP_STRUCT_OFS) begin
			rsp_d.rdata = STRUCT_VAL;
		end else if (req.addr == ECP_CAP_OFS) begin
			rsp_d.rdata = CAP_VAL;
		end else begin
			rsp_d.rdata = ECP_ZERO;  // Unmapped
		end
	end

	// Answer register
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rsp_q <= '0;
		end else begin
			rsp_q <= rsp_d;
		end
	end

	assign rsp = rsp_q;

	// ------------------------------------------------------------
	// Decoded flag state
	// ------------------------------------------------------------
	// Held in flops so every output is registered; they never change
	logic        rmf_q, rmf_d;
	logic        psf_q, psf_d;
	logic        fls_q, fls_d;
	logic        acf_q, acf_d;
	logic [3:0]  cnt_q, cnt_d;
	logic [59:0] rte_q, rte_d;

	// Next values equal the built-in constants; no write path exists
	always_comb begin
		rmf_d = STRUCT_VAL[ECP_PRR_BIT];
		psf_d = STRUCT_VAL[ECP_PPC_BIT];
		fls_d = CAP_VAL[ECP_FRAME_LIST_FLAG_BIT];
		acf_d = CAP_VAL[ECP_AC64_BIT];
		cnt_d = STRUCT_VAL[ECP_PORTS_LSB +: ECP_NIB];
		rte_d = ROUTE_VAL;
	end

	// Flag registers, reset straight to the built-in values
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			rmf_q <= STRUCT_VAL[ECP_PRR_BIT];
			psf_q <= STRUCT_VAL[ECP_PPC_BIT];
			fls_q <= CAP_VAL[ECP_FRAME_LIST_FLAG_BIT];
			acf_q <= CAP_VAL[ECP_AC64_BIT];
			cnt_q <= STRUCT_VAL[ECP_PORTS_LSB +: ECP_NIB];
			rte_q <= ROUTE_VAL;
		end else begin
			rmf_q <= rmf_d;
			psf_q <= psf_d;
			fls_q <= fls_d;
			acf_q <= acf_d;
			cnt_q <= cnt_d;
			rte_q <= rte_d;
		end
	end

	assign routing_method_flag        = rmf_q;
	assign port_power_switch_flag     = psf_q;
	assign frame_list_size_writable   = fls_q;
	assign addressing_capability_flag = acf_q;
	assign port_count                 = cnt_q;
	assign companion_route_array      = rte_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	wire rd_struct = req.valid && !req.write && (req.addr == ECP_STRUCT_OFS);
	wire rd_cap    = req.valid && !req.write && (req.addr == ECP_CAP_OFS);

	chk_route_bit: assert property (rd_struct |=> rsp.ack && rsp.rdata[ECP_PRR_BIT] == routing_method_flag)
		else $error("routing flag read mismatch");
	chk_power_bit: assert property (rd_struct |=> rsp.rdata[ECP_PPC_BIT] == port_power_switch_flag)
		else $error("power switch flag read mismatch");
	chk_port_nonzero: assert property (rd_struct |=> rsp.rdata[3:0] != 4'h0 && rsp.rdata[3:0] == port_count)
		else $error("port count zero or mismatched");
	chk_cap_word: assert property (rd_cap |=> rsp.ack && rsp.rdata == 32'h0000_0012)
		else $error("capability word wrong");
	chk_write_ignored: assert property (req.valid && req.write |=> rsp.ack && rsp.rdata == 32'h0 ##1 $stable(companion_route_array))
		else $error("write had an effect");
	chk_ack_single: assert property (!req.valid |=> !rsp.ack)
		else $error("answer without request");
	chk_pcc_field: assert property (rd_struct |=> rsp.rdata[11:8] != 4'h0 && rsp.rdata[31:16] == 16'h0)
		else $error("ports per companion field bad");
	// Companions times group size must cover the ports, unless no companion exists
	chk_pcc_consist: assert property (rd_struct |=> rsp.rdata[15:12] == 4'h0 ||
		int'(rsp.rdata[11:8]) * int'(rsp.rdata[15:12]) >= int'(rsp.rdata[3:0]))
		else $error("ports per companion inconsistent");
	// Every entry at or beyond the port count must read zero, whatever the build
	chk_route_valid: assert property ((companion_route_array >> (int'(port_count) * ECP_NIB)) == 60'h0)
		else $error("route entry beyond port count");
	chk_group_route: assert property (!routing_method_flag |-> companion_route_array[3:0] == 4'h0)
		else $error("first port not on lowest companion");
	chk_flags_steady: assert property (##1 $stable(frame_list_size_writable) && $stable(addressing_capability_flag))
		else $error("capability flags changed");
endmodule : ecp_params
`default_nettype wire

// ==== verif/tb.sv ====
/*
 * Self-checking bench for the capability parameter bank: reset values,
 * both words, unmapped and write accesses, back-to-back reads, a mid-run reset.
 * Assumes the ecp_pkg package and ecp_params are compiled first.
 */
`timescale 1ns/1ps
`default_nettype none
module tb;
	import ecp_pkg::*;
	// ------------------------------------------------------------
	// Stimulus and observed signals
	// ------------------------------------------------------------
	logic        clk;        // 100 MHz clock
	logic        reset;      // Async, active high
	ecp_req_t    req;        // Shared by every instance
	ecp_rsp_t    rsp [3];    // Answers per instance
	ecp_rsp_t    cap [3];    // Answers captured after the ack edge
	logic        rm  [3];    // Routing method flags
	logic        ps  [3];    // Power switch flags
	logic        fw  [3];    // Frame list size writable
	logic        ac  [3];    // Addressing flags
	logic [3:0]  pc  [3];    // Port counts
	logic [59:0] ra  [3];    // Route arrays
	int          failures  = 0;
	int          tests_run = 0;
	// Expected values: defaults, implicit grouping, zero port count
	logic [31:0] es [3] = '{32'h00002192, 32'h00002204, 32'h00002191};
	logic [59:0] er [3] = '{60'h10, 60'h1100, 60'h0};
	logic [3:0]  ep [3] = '{4'h2, 4'h4, 4'h1};
	logic        ef [3] = '{1'b1, 1'b0, 1'b1};
	// ------------------------------------------------------------
	// Three builds: default, implicit routing, zero port count
	// ------------------------------------------------------------
	ecp_params i_dut (.clk(clk), .reset(reset), .req(req), .rsp(rsp[0]), .routing_method_flag(rm[0]),
		.port_power_switch_flag(ps[0]), .frame_list_size_writable(fw[0]),
		.addressing_capability_flag(ac[0]), .port_count(pc[0]), .companion_route_array(ra[0]));
	ecp_params #(.PORTS(4'h4), .PER_COMP(4'h2), .POWER_SW(1'b0), .ROUTE_EXPL(1'b0)) i_dut2 (.clk(clk),
		.reset(reset), .req(req), .rsp(rsp[1]), .routing_method_flag(rm[1]),
		.port_power_switch_flag(ps[1]), .frame_list_size_writable(fw[1]),
		.addressing_capability_flag(ac[1]), .port_count(pc[1]), .companion_route_array(ra[1]));
	ecp_params #(.PORTS(4'h0)) i_dut3 (.clk(clk), .reset(reset), .req(req), .rsp(rsp[2]),
		.routing_method_flag(rm[2]), .port_power_switch_flag(ps[2]), .frame_list_size_writable(fw[2]),
		.addressing_capability_flag(ac[2]), .port_count(pc[2]), .companion_route_array(ra[2]));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// One request, answer captured just after the edge that takes it
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		req <= '{valid: 1'b1, write: w, addr: a, wdata: d};
		@(posedge clk);
		req.valid <= 1'b0;
		#1;
		cap = rsp;
	endtask
	task automatic conclude;
		$display("tests_run %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_flags;
		for (int i = 0; i < 3; i++) begin
			check("routing flag", rm[i], ef[i]);
			check("power flag", ps[i], ef[i]);
			check("port count", pc[i], ep[i]);
			check("route array", ra[i], er[i]);
			check("frame list flag", fw[i], 1'b1);
			check("addressing flag", ac[i], 1'b0);
		end
	endtask
	// Both words on every build, then an unmapped offset
	task automatic t_reads;
		xfer(1'b0, ECP_STRUCT_OFS, 32'h0);
		for (int i = 0; i < 3; i++) check("struct word", {cap[i].ack, cap[i].rdata}, {1'b1, es[i]});
		xfer(1'b0, ECP_CAP_OFS, 32'h0);
		for (int i = 0; i < 3; i++) check("cap word", {cap[i].ack, cap[i].rdata}, 33'h100000012);
		xfer(1'b0, 8'h10, 32'h0);
		check("unmapped", {cap[0].ack, cap[0].rdata}, 33'h100000000);
	endtask
	// Writes of all ones must change nothing
	task automatic t_writes;
		xfer(1'b1, ECP_STRUCT_OFS, 32'hffffffff);
		check("write struct", {cap[0].ack, cap[0].rdata}, 33'h100000000);
		xfer(1'b1, ECP_CAP_OFS, 32'hffffffff);
		check("write cap", {cap[1].ack, cap[1].rdata}, 33'h100000000);
		t_reads();
		t_flags();
	endtask
	// A request on every cycle; each answer stands for one cycle only
	task automatic t_back2back;
		logic [7:0]  a [4] = '{8'h08, 8'h04, 8'h04, 8'h08};
		logic [31:0] e [4] = '{32'h12, 32'h2192, 32'h2192, 32'h12};
		@(posedge clk);
		req <= '{valid: 1'b1, write: 1'b0, addr: a[0], wdata: 32'h0};
		for (int i = 1; i <= 4; i++) begin
			@(posedge clk);
			if (i < 4) req.addr <= a[i];
			else req.valid <= 1'b0;
			#1;
			check("b2b word", {rsp[0].ack, rsp[0].rdata}, {1'b1, e[i-1]});
		end
		@(posedge clk);
		#1;
		check("b2b idle", {rsp[0].ack, rsp[0].rdata}, 33'h0);
	endtask
	// Reset lands on the edge that takes a read
	task automatic t_mid_reset;
		@(posedge clk);
		req <= '{valid: 1'b1, write: 1'b0, addr: ECP_STRUCT_OFS, wdata: 32'h0};
		@(posedge clk);
		req.valid <= 1'b0;
		reset <= 1'b1;
		#1;
		check("reset answer", {rsp[0].ack, rsp[0].rdata}, 33'h0);
		t_flags();
		@(posedge clk);
		reset <= 1'b0;
		t_reads();
	endtask
	// ------------------------------------------------------------
	// Clock, watchdog and main sequence
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Whole run is well under 100 cycles; 2000 leaves ample margin
	initial begin
		#20000;
		failures++;
		conclude();
	end
	initial begin
		reset = 1'b1;
		req   = '0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		#1;
		check("idle answer", {rsp[0].ack, rsp[0].rdata}, 33'h0);
		t_flags();
		t_reads();
		t_writes();
		t_back2back();
		t_mid_reset();
		conclude();
	end
endmodule // tb
`default_nettype wire
